/* rtl/supervisor_pkg.sv */
// Constants and state encoding of the supply unit supervisor
package supervisor_pkg;
    localparam int CLK_FREQ_HZ = 25000000;
    localparam int CYCLES_PER_MS = CLK_FREQ_HZ / 1000;
    // Minimum fault reset pulse width in ms
    localparam int RESET_PULSE_MS = 100;
    // Line-present output settling delay in ms
    localparam int LINE_DELAY_MS = 20;
    // Self test, calibration and charging times in ms
    localparam int SELF_TEST_MS = 50;
    localparam int CALIBRATE_MS = 20;
    localparam int CHARGE_TIME_MS = 4000;
    // Default recovery lockout in ms
    localparam int LOCKOUT_MS = 5000;
    localparam int MS_WIDTH = 16;

    typedef enum logic [3:0] {
        ST_SUPPLY_MISSING = 4'h0,
        ST_FW_STARTUP = 4'h1,
        ST_SELF_TEST = 4'h2,
        ST_CALIBRATE = 4'h3,
        ST_LINE_WAIT = 4'h4,
        ST_OUTPUT_CHECK = 4'h5,
        ST_OPERATIONAL = 4'h6,
        ST_WARNING = 4'h7,
        ST_FAULT = 4'h8,
        ST_POWER_DOWN = 4'h9
    } state_t;
endpackage

/* rtl/reset_pulse_qualifier.sv */
// Measures fault reset input high time and emits one request per long pulse
`timescale 1ns/1ps
module reset_pulse_qualifier
    import supervisor_pkg::*;
#(
    parameter int MIN_MS = RESET_PULSE_MS
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ms_tick,
    input wire logic level,
    output logic request
);
    initial begin
        if (MIN_MS < 1 || MIN_MS > 60000) begin
            $error("MIN_MS out of range");
        end
    end

    logic [MS_WIDTH-1:0] high_ms;
    logic fired;

    // Count whole ms while high; fire once per pulse, rearm on low
    // A tick may land just after the rise, so one extra tick proves the full MIN_MS
    always_ff @(posedge sys_clk) begin
        if (reset || !level) begin
            high_ms <= '0;
            fired <= 1'b0;
            request <= 1'b0;
        end else begin
            request <= 1'b0;
            if (ms_tick && high_ms != MS_WIDTH'(MIN_MS + 1)) begin
                high_ms <= high_ms + MS_WIDTH'(1); // R25
            end
            if (high_ms == MS_WIDTH'(MIN_MS + 1) && !fired) begin
                request <= 1'b1; // R01 R25
                fired <= 1'b1;
            end
        end
    end

    a_short_pulse: assert property (@(posedge sys_clk) disable iff (reset) // R01
        request |-> high_ms == MS_WIDTH'(MIN_MS + 1) && $past(level))
        else $error("reset request from short pulse");
    a_one_request: assert property (@(posedge sys_clk) disable iff (reset) // R25
        request |=> !request)
        else $error("request longer than one cycle");
endmodule

/* rtl/supply_unit_state_supervisor.sv */
// Supervisory state machine of a DC-bus supply unit
`timescale 1ns/1ps
// Contract
// R01: Fault reset input must stay high at least 100 ms to count.
// R02: Bus-ready on only when ready to operate and fault free.
// R03: After fault and contact release, bus-ready turns off.
// R04: Line-present on when two or three phases exceed minimum.
// R05: Line-present follows line condition after about 20 ms.
// R06: Fault indicator on whenever a malfunction is detected; fault_detect is ignored outside the running states and the fault state.
// R07: Any malfunction opens the contactor enable contact.
// R08: Reset accepted only from dedicated input, never from bus.
// R09: Contact held open while control supply is absent.
// R10: Startup runs self test with discharge, then calibration, then line wait.
// R11: Line wait closes contact until input voltage within limits.
// R12: Output check needs bus voltage within limits inside charge time.
// R13: Output check needs ripple below safety threshold.
// R14: End of output check goes operational if all good, else fault.
// R15: Operational has line-present and line-absent sub-conditions.
// R16: Warning threshold exceeded enters warning, supply continues.
// R17: Entering fault opens contact and starts lockout timer.
// R18: After lockout, recheck cause and recover to line wait if cleared.
// R19: Control undervoltage enters power-down and opens contact.
// R20: Supply return after power-down goes to supply-missing, reports error.
// R21: Qualified reset edge returns fault to line wait if allowed.
// R22: Errors stay latched until next reset; error_latch and supply_missing_error clear on the next entry to line wait.
// R23: Reset refused until lockout time has elapsed.
// R24: Reset pulses outside fault state are ignored.
// R25: Reset high time measured by timebase, one request per pulse.
module supply_unit_state_supervisor
    import supervisor_pkg::*;
#(
    parameter int LOCKOUT_TIME_MS = LOCKOUT_MS,
    parameter int CHARGE_MS = CHARGE_TIME_MS,
    parameter int TEST_MS = SELF_TEST_MS,
    parameter int CAL_MS = CALIBRATE_MS,
    parameter int LINE_MS = LINE_DELAY_MS,
    parameter int PULSE_MS = RESET_PULSE_MS,
    parameter int TICK_CYCLES = CYCLES_PER_MS
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic control_supply_ok,
    input wire logic fw_started,
    input wire logic [2:0] phase_present,
    input wire logic input_in_limits,
    input wire logic output_in_limits,
    input wire logic ripple_ok,
    input wire logic warning_detect,
    input wire logic fault_detect,
    input wire logic auto_recovery_enable,
    input wire logic fault_reset_pin,
    output logic contactor_enable_contact,
    output logic bus_ready_output,
    output logic line_present_output,
    output logic fault_indicator_output,
    output logic supply_missing_error,
    output logic line_sub_present,
    output state_t state
);
    initial begin
        if (TICK_CYCLES < 1 || LOCKOUT_TIME_MS < 1 || CHARGE_MS < 1 ||
            TEST_MS < 1 || CAL_MS < 1 || LINE_MS < 1 ||
            LOCKOUT_TIME_MS > 65535 || CHARGE_MS > 65535 || TEST_MS > 65535 ||
            CAL_MS > 65535 || LINE_MS > 65535 || TICK_CYCLES > 65536) begin
            $error("timing parameters out of range");
        end
    end

    // Two-flop synchronisers for every pin-level input except auto_recovery_enable
    logic [10:0] sync_a;
    logic [10:0] sync_b;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {control_supply_ok, fw_started, phase_present, input_in_limits,
                output_in_limits, ripple_ok, warning_detect, fault_detect,
                fault_reset_pin};
            sync_b <= sync_a;
        end
    end
    logic supply_ok_s, fw_s, in_ok_s, out_ok_s, ripple_s, warn_s, fault_s, rst_pin_s;
    logic [2:0] phases_s;
    assign {supply_ok_s, fw_s, phases_s, in_ok_s, out_ok_s, ripple_s, warn_s, fault_s,
        rst_pin_s} = sync_b;

    // Millisecond timebase shared by all timers
    logic [15:0] tick_div;
    logic ms_tick;
    always_ff @(posedge sys_clk) begin
        if (reset || tick_div == 16'(TICK_CYCLES - 1)) begin
            tick_div <= '0;
        end else begin
            tick_div <= tick_div + 16'h0001;
        end
    end
    assign ms_tick = (tick_div == 16'(TICK_CYCLES - 1));

    function automatic logic two_of_three(input logic [2:0] p);
        return (p[0] & p[1]) | (p[0] & p[2]) | (p[1] & p[2]);
    endfunction

    logic reset_request;
    reset_pulse_qualifier #(
        .MIN_MS(PULSE_MS)
    ) u_qualifier (
        .sys_clk(sys_clk),
        .reset(reset),
        .ms_tick(ms_tick),
        .level(rst_pin_s),
        .request(reset_request)
    );

    // Line-present filter: the output moves on the LINE_MS-th ms tick for which the condition has differed from it
    logic line_raw;
    logic [MS_WIDTH-1:0] line_ms;
    assign line_raw = two_of_three(phases_s); // R04
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            line_ms <= '0;
            line_present_output <= 1'b0;
        end else if (line_raw == line_present_output) begin
            line_ms <= '0;
        end else if (ms_tick) begin
            if (line_ms == MS_WIDTH'(LINE_MS - 1)) begin
                line_present_output <= line_raw; // R05
                line_ms <= '0;
            end else begin
                line_ms <= line_ms + MS_WIDTH'(1);
            end
        end
    end

    // State timer in ms, cleared on every state change
    state_t next_state;
    logic [MS_WIDTH-1:0] state_ms;
    always_ff @(posedge sys_clk) begin
        if (reset || next_state != state) begin
            state_ms <= '0;
        end else if (ms_tick && state_ms != '1) begin
            state_ms <= state_ms + MS_WIDTH'(1);
        end
    end

    // Latched error, kept until a granted recovery, a full supply cycle or reset
    logic error_latch;
    logic lockout_done;
    assign lockout_done = (state == ST_FAULT) &&
        (state_ms >= MS_WIDTH'(LOCKOUT_TIME_MS)); // R17 R23
    logic recover;
    // Bus resets have no path here; only the qualified pin pulse counts
    assign recover = lockout_done && !fault_s &&
        (reset_request || auto_recovery_enable); // R08 R18 R21 R23 R24

    // State transitions
    always_comb begin
        next_state = state;
        case (state)
            ST_SUPPLY_MISSING: begin
                if (supply_ok_s) begin
                    next_state = ST_FW_STARTUP;
                end
            end
            ST_FW_STARTUP: begin
                if (fw_s) begin
                    next_state = ST_SELF_TEST; // R10
                end
            end
            ST_SELF_TEST: begin
                if (state_ms >= MS_WIDTH'(TEST_MS)) begin
                    next_state = ST_CALIBRATE; // R10
                end
            end
            ST_CALIBRATE: begin
                if (state_ms >= MS_WIDTH'(CAL_MS)) begin
                    next_state = ST_LINE_WAIT; // R10
                end
            end
            ST_LINE_WAIT: begin
                if (in_ok_s) begin
                    next_state = ST_OUTPUT_CHECK; // R11
                end
            end
            ST_OUTPUT_CHECK: begin
                if (!ripple_s) begin
                    next_state = ST_FAULT; // R13
                end else if (out_ok_s) begin
                    next_state = ST_OPERATIONAL; // R12 R14
                end else if (state_ms >= MS_WIDTH'(CHARGE_MS)) begin
                    next_state = ST_FAULT; // R14
                end
            end
            ST_OPERATIONAL: begin
                if (warn_s) begin
                    next_state = ST_WARNING; // R16
                end
            end
            ST_WARNING: begin
                if (!warn_s) begin
                    next_state = ST_OPERATIONAL;
                end
            end
            ST_FAULT: begin
                if (recover) begin
                    next_state = ST_LINE_WAIT; // R18 R21
                end
            end
            ST_POWER_DOWN: begin
                if (supply_ok_s) begin
                    next_state = ST_SUPPLY_MISSING; // R20
                end
            end
            default: next_state = ST_SUPPLY_MISSING;
        endcase
        // Malfunctions preempt the running states; undervoltage preempts all but supply missing
        if (fault_s && (state == ST_OUTPUT_CHECK || state == ST_OPERATIONAL ||
            state == ST_WARNING || state == ST_LINE_WAIT)) begin
            next_state = ST_FAULT; // R07
        end
        if (!supply_ok_s && state != ST_POWER_DOWN && state != ST_SUPPLY_MISSING) begin
            next_state = ST_POWER_DOWN; // R19
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= ST_SUPPLY_MISSING;
        end else begin
            state <= next_state;
        end
    end

    // Error latch: set wins over the recovery clear
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            error_latch <= 1'b0;
        end else if (next_state == ST_FAULT) begin
            error_latch <= 1'b1; // R22
        end else if (next_state == ST_LINE_WAIT) begin
            // Recovery and a full control-supply cycle both come back through line wait
            error_latch <= 1'b0;
        end
    end

    // Supply missing error is reported after a power-down until the restart reaches line wait
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            supply_missing_error <= 1'b0;
        end else if (state == ST_POWER_DOWN && next_state == ST_SUPPLY_MISSING) begin
            supply_missing_error <= 1'b1; // R20
        end else if (next_state == ST_LINE_WAIT) begin
            supply_missing_error <= 1'b0;
        end
    end

    // Outputs registered; contact closes only in running states with supply present
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            contactor_enable_contact <= 1'b0;
            bus_ready_output <= 1'b0;
            fault_indicator_output <= 1'b0;
            line_sub_present <= 1'b0;
        end else begin
            contactor_enable_contact <= supply_ok_s && (next_state == ST_LINE_WAIT ||
                next_state == ST_OUTPUT_CHECK || next_state == ST_OPERATIONAL ||
                next_state == ST_WARNING); // R07 R09 R11 R17 R19
            // Drops one cycle after the contact opens on a fault
            bus_ready_output <= contactor_enable_contact && !error_latch &&
                (state == ST_OPERATIONAL || state == ST_WARNING); // R02 R03
            fault_indicator_output <= error_latch || next_state == ST_FAULT; // R06
            line_sub_present <= (next_state == ST_OPERATIONAL) &&
                line_present_output; // R15
        end
    end

    a_contact_fault: assert property (@(posedge sys_clk) disable iff (reset) // R07
        state == ST_FAULT |-> !contactor_enable_contact)
        else $error("contact closed in fault state");
    a_contact_nosupply: assert property (@(posedge sys_clk) disable iff (reset) // R09
        !supply_ok_s |=> !contactor_enable_contact)
        else $error("contact closed without supply");
    a_ready_fault: assert property (@(posedge sys_clk) disable iff (reset) // R03
        fault_indicator_output && !contactor_enable_contact |=> !bus_ready_output)
        else $error("bus ready with fault and open contact");
    a_ready_state: assert property (@(posedge sys_clk) disable iff (reset) // R02
        bus_ready_output |-> $past(state == ST_OPERATIONAL || state == ST_WARNING))
        else $error("bus ready outside operation");
    a_fault_flag: assert property (@(posedge sys_clk) disable iff (reset) // R06
        state == ST_FAULT |-> fault_indicator_output)
        else $error("fault indicator off in fault state");
    a_lockout_hold: assert property (@(posedge sys_clk) disable iff (reset) // R23
        state == ST_FAULT && state_ms < MS_WIDTH'(LOCKOUT_TIME_MS) && supply_ok_s
        |=> state == ST_FAULT)
        else $error("left fault before lockout");
    a_stray_pulse: assert property (@(posedge sys_clk) disable iff (reset) // R24
        state == ST_OPERATIONAL && reset_request && !warn_s && !fault_s && supply_ok_s
        |=> state == ST_OPERATIONAL)
        else $error("reset pulse disturbed operation");
    a_line_follow: assert property (@(posedge sys_clk) disable iff (reset) // R05
        line_present_output != $past(line_present_output) |->
        line_present_output == $past(line_raw))
        else $error("line output changed without condition");
    a_powerdown: assert property (@(posedge sys_clk) disable iff (reset) // R19
        state == ST_OPERATIONAL && !supply_ok_s |=> state == ST_POWER_DOWN)
        else $error("no power down on undervoltage");

    c_reach_operational: cover property (@(posedge sys_clk) state == ST_OPERATIONAL);
    c_recover_pin: cover property (@(posedge sys_clk) state == ST_FAULT && reset_request
        ##1 state == ST_LINE_WAIT);
    c_warning: cover property (@(posedge sys_clk) state == ST_WARNING);
    c_power_cycle: cover property (@(posedge sys_clk) state == ST_POWER_DOWN
        ##1 state == ST_SUPPLY_MISSING);
endmodule

/* tb/controller_contactor_model.sv */
// Machine controller reset output and upstream line contactor
`timescale 1ns/1ps
module controller_contactor_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic contactor_enable_contact,
    input wire logic [2:0] mains_phases,
    input wire logic pulse_start,
    input wire logic [15:0] pulse_cycles,
    output logic fault_reset_pin,
    output logic [2:0] phase_present
);
    logic [15:0] remaining;

    // Open contactor leaves the phases dead, so the unit sees no line at all
    assign phase_present = contactor_enable_contact ? mains_phases : 3'h0;

    // Pulse length counter, loaded by the bench and run down once per cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            remaining <= 16'h0;
        end else if (pulse_start) begin
            remaining <= pulse_cycles;
        end else if (remaining != 16'h0) begin
            remaining <= remaining - 16'h1;
        end
    end

    // Pin high for exactly the commanded span, then low again
    assign fault_reset_pin = (remaining != 16'h0);
endmodule

/* tb/supply_unit_state_supervisor_test.sv */
// Self-checking bench of the supply unit supervisor
`timescale 1ns/1ps
module supply_unit_state_supervisor_test
    import supervisor_pkg::*;
();
    localparam int TICK = 10;
    localparam int PULSE = 3;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic control_supply_ok = 1'h0;
    logic fw_started = 1'h0;
    logic input_in_limits = 1'h0;
    logic output_in_limits = 1'h0;
    logic ripple_ok = 1'h1;
    logic warning_detect = 1'h0;
    logic fault_detect = 1'h0;
    logic auto_recovery_enable = 1'h0;
    logic [2:0] mains_phases = 3'h0;
    logic pulse_start = 1'h0;
    logic [15:0] pulse_cycles = 16'h0;
    logic fault_reset_pin;
    logic [2:0] phase_present;
    logic contactor_enable_contact;
    logic bus_ready_output;
    logic line_present_output;
    logic fault_indicator_output;
    logic supply_missing_error;
    logic line_sub_present;
    state_t state;
    int failures = 0;
    int check_count = 0;
    logic [2:0] cases [8] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h7, 3'h1, 3'h6, 3'h2};

    supply_unit_state_supervisor #(
        .LOCKOUT_TIME_MS(5), .CHARGE_MS(20), .TEST_MS(2), .CAL_MS(2),
        .LINE_MS(2), .PULSE_MS(PULSE), .TICK_CYCLES(TICK)
    ) i_supply_unit_state_supervisor (
        .sys_clk(sys_clk), .reset(reset), .control_supply_ok(control_supply_ok),
        .fw_started(fw_started), .phase_present(phase_present),
        .input_in_limits(input_in_limits), .output_in_limits(output_in_limits),
        .ripple_ok(ripple_ok), .warning_detect(warning_detect), .fault_detect(fault_detect),
        .auto_recovery_enable(auto_recovery_enable), .fault_reset_pin(fault_reset_pin),
        .contactor_enable_contact(contactor_enable_contact),
        .bus_ready_output(bus_ready_output), .line_present_output(line_present_output),
        .fault_indicator_output(fault_indicator_output),
        .supply_missing_error(supply_missing_error), .line_sub_present(line_sub_present),
        .state(state)
    );

    controller_contactor_model i_controller_contactor_model (
        .sys_clk(sys_clk), .reset(reset), .contactor_enable_contact(contactor_enable_contact),
        .mains_phases(mains_phases), .pulse_start(pulse_start), .pulse_cycles(pulse_cycles),
        .fault_reset_pin(fault_reset_pin), .phase_present(phase_present)
    );

    // 25 MHz clock
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    // Two or three live phases count as line present
    function automatic logic line_expect(input logic [2:0] p);
        return (int'(p[0]) + int'(p[1]) + int'(p[2])) >= 2;
    endfunction

    task automatic check_bit(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_state(input state_t exp);
        check_count++;
        if (state !== exp) begin
            failures++;
            $display("MISMATCH state expected %h seen %h", exp, state);
        end
    endtask

    // Polls on the falling edge so the launching edge has settled first
    task automatic wait_state(input state_t s, input int limit);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (state !== s && n < limit);
        check_state(s);
    endtask

    task automatic pulse(input int n);
        @(posedge sys_clk);
        pulse_cycles <= 16'(n);
        pulse_start <= 1'h1;
        @(posedge sys_clk);
        pulse_start <= 1'h0;
        repeat (n + 5) @(posedge sys_clk);
    endtask

    task automatic print_verdict();
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Whole run needs well under two thousand cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        print_verdict();
    end

    initial begin
        logic exp_prev;
        logic exp;
        void'($urandom(28));
        repeat (10) @(posedge sys_clk);
        reset <= 1'h0;
        repeat (20) @(negedge sys_clk);
        check_state(ST_SUPPLY_MISSING);
        check_bit("contact", 1'h0, contactor_enable_contact);
        @(posedge sys_clk);
        control_supply_ok <= 1'h1;
        wait_state(ST_FW_STARTUP, 10);
        check_bit("contact", 1'h0, contactor_enable_contact);
        @(posedge sys_clk);
        fw_started <= 1'h1;
        wait_state(ST_SELF_TEST, 10);
        wait_state(ST_CALIBRATE, 40);
        wait_state(ST_LINE_WAIT, 40);
        check_bit("contact", 1'h1, contactor_enable_contact);
        check_bit("bus_ready", 1'h0, bus_ready_output);
        repeat (30) @(negedge sys_clk);
        check_state(ST_LINE_WAIT);
        @(posedge sys_clk);
        input_in_limits <= 1'h1;
        wait_state(ST_OUTPUT_CHECK, 10);
        @(posedge sys_clk);
        output_in_limits <= 1'h1;
        wait_state(ST_OPERATIONAL, 30);
        @(negedge sys_clk);
        check_bit("bus_ready", 1'h1, bus_ready_output);
        // Hand-picked phase patterns first, then random ones
        exp_prev = 1'h0;
        for (int i = 0; i < 14; i++) begin
            @(posedge sys_clk);
            mains_phases <= (i < 8) ? cases[i] : 3'($urandom);
            exp = line_expect((i < 8) ? cases[i] : mains_phases);
            @(posedge sys_clk);
            exp = line_expect(mains_phases);
            repeat (5) @(negedge sys_clk);
            check_bit("line_present_early", exp_prev, line_present_output);
            repeat (40) @(negedge sys_clk);
            check_bit("line_present", exp, line_present_output);
            check_bit("line_sub_present", exp, line_sub_present);
            exp_prev = exp;
        end
        @(posedge sys_clk);
        warning_detect <= 1'h1;
        wait_state(ST_WARNING, 10);
        check_bit("contact", 1'h1, contactor_enable_contact);
        @(posedge sys_clk);
        warning_detect <= 1'h0;
        wait_state(ST_OPERATIONAL, 10);
        // Long enough to qualify whatever the tick phase
        pulse(PULSE * TICK + 20);
        check_state(ST_OPERATIONAL);
        @(posedge sys_clk);
        fault_detect <= 1'h1;
        wait_state(ST_FAULT, 10);
        check_bit("contact", 1'h0, contactor_enable_contact);
        check_bit("fault_ind", 1'h1, fault_indicator_output);
        // Bus ready falls one cycle after the contact has opened
        @(negedge sys_clk);
        check_bit("bus_ready", 1'h0, bus_ready_output);
        @(posedge sys_clk);
        fault_detect <= 1'h0;
        // Long pulse that qualifies before the lockout has run out
        pulse(PULSE * TICK + 5);
        check_state(ST_FAULT);
        check_bit("fault_ind", 1'h1, fault_indicator_output);
        repeat (40) @(posedge sys_clk);
        // One cycle short of the minimum width
        pulse(PULSE * TICK - 1);
        check_state(ST_FAULT);
        input_in_limits <= 1'h0;
        pulse(PULSE * TICK + 20 + int'($urandom % 20));
        wait_state(ST_LINE_WAIT, 20);
        check_bit("contact", 1'h1, contactor_enable_contact);
        @(posedge sys_clk);
        ripple_ok <= 1'h0;
        input_in_limits <= 1'h1;
        wait_state(ST_OUTPUT_CHECK, 10);
        wait_state(ST_FAULT, 300);
        repeat (30) @(negedge sys_clk);
        check_state(ST_FAULT);
        @(posedge sys_clk);
        ripple_ok <= 1'h1;
        input_in_limits <= 1'h0;
        auto_recovery_enable <= 1'h1;
        wait_state(ST_LINE_WAIT, 100);
        // Bus never charges: must wait out the charge time, then fault
        @(posedge sys_clk);
        auto_recovery_enable <= 1'h0;
        output_in_limits <= 1'h0;
        input_in_limits <= 1'h1;
        wait_state(ST_OUTPUT_CHECK, 10);
        repeat (150) @(negedge sys_clk);
        check_state(ST_OUTPUT_CHECK);
        wait_state(ST_FAULT, 100);
        @(posedge sys_clk);
        output_in_limits <= 1'h1;
        auto_recovery_enable <= 1'h1;
        wait_state(ST_OPERATIONAL, 200);
        @(posedge sys_clk);
        auto_recovery_enable <= 1'h0;
        control_supply_ok <= 1'h0;
        wait_state(ST_POWER_DOWN, 10);
        check_bit("contact", 1'h0, contactor_enable_contact);
        @(posedge sys_clk);
        control_supply_ok <= 1'h1;
        wait_state(ST_SUPPLY_MISSING, 10);
        check_bit("supply_missing", 1'h1, supply_missing_error);
        wait_state(ST_OPERATIONAL, 200);
        check_bit("supply_missing", 1'h0, supply_missing_error);
        print_verdict();
    end
endmodule
